//--- hw/swc_pkg.sv
// Purpose: shared constants and types for the sleep and wake controller
// Assumes: 25 MHz core clock
// Notes: register offsets are byte addresses on a 32-bit Avalon-MM slave
package swc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;    // Control: watchdog enable, oscillator mode
  localparam logic [3:0] ADDR_STATUS = 4'h4;  // Status: flags, state, wake cause
  localparam logic [3:0] ADDR_INT_EN = 4'h8;  // Per-source wake enables

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_WDT_EN_BIT = 0;
  localparam int CTRL_XTAL_BIT = 1;
  localparam int NUM_WAKE_SRC = 7;
  localparam logic [12:0] INT_VECTOR = 13'h0004;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [6:0] INT_EN_RESET = 7'h00;
  localparam int OST_PERIODS = 1024;          // Oscillator start-up in oscillator periods
  localparam int OST_CYCLES = OST_PERIODS;    // One core clock per oscillator period
  localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);

  // Controller states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_OST,
    ST_RESUME
  } swc_state_type;

  // Wake causes
  typedef enum logic [1:0] {
    WAKE_NONE,
    WAKE_WDT,
    WAKE_INT
  } swc_cause_type;

endpackage

//--- hw/swc_ost_timer.sv
// Purpose: oscillator start-up counter for the sleep and wake controller
// Assumes: start is a one-cycle pulse
// Notes: done pulses once, OST_CYCLES cycles after start
`timescale 1ns/10ps
module swc_ost_timer (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Control
  input wire logic i_start,
  output logic o_done
);

  logic [10:0] count_q;
  logic busy_q;

  // Count oscillator periods until the crystal is deemed stable
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      count_q <= 11'h000;
      busy_q <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        count_q <= 11'h000;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (count_q == swc_pkg::OST_LAST) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count_q <= count_q + 11'h001;
        end
      end
    end
  end

endmodule

//--- hw/swc_sleep_ctrl.sv
// Purpose: power-down entry and wake control for a small microcontroller core
// Assumes: core presents a one-cycle halt strobe; flags are synchronous inputs
// Notes: registers reached over Avalon-MM; reads answer one cycle after request
//
// Summary of operation
// - Power-down is entered only on the core's halt instruction.
// - With watchdog enabled, entry clears its count and keeps it running.
// - Completed entry clears power-down flag and sets time-out flag.
// - Main oscillator driver off in power-down; timer oscillator untouched.
// - I/O ports hold their prior drive state during power-down.
// - A watchdog reset never drives the master clear pin low.
// - Master clear wake performs a full device reset.
// - Watchdog or interrupt wake resumes execution, no reset.
// - Power-down flag set on power-up; time-out flag cleared on watchdog wake.
// - Only the listed asynchronous-capable interrupt sources may wake.
// - No other peripheral raises a wake interrupt in power-down.
// - During halt the core prefetches the instruction at PC plus one.
// - Interrupt wakes only if its own enable is set, ignoring global enable.
// - Global enable clear: continue with instruction after halt.
// - Global enable set: run next instruction then branch to handler.
// - Watchdog cleared on every wake from power-down.
// - Pending enabled flag before halt makes halt a no-operation.
// - Flag rising during or after halt: complete entry then wake at once.
// - Interrupt wake with global enable branches to the fixed vector.
// - Crystal modes wait 1024 oscillator periods on wake; others skip.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module swc_sleep_ctrl (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Power-on indication: high for the first cycle after power-up
  input wire logic i_power_on,
  // Core interface
  input wire logic i_halt,
  input wire logic i_global_int_enable,
  input wire logic [12:0] i_pc,
  // Wake sources: timer_one, serial rx, converter, pin change, ext int,
  // capture units, sync_serial_port slave
  input wire logic [6:0] i_int_flags,
  input wire logic i_watchdog_timeout,
  input wire logic i_master_clear_pin,
  // I/O drive state from the port logic
  input wire logic [7:0] i_port_out,
  input wire logic [7:0] i_port_oe,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core control
  output logic o_core_stall,
  output logic o_prefetch_en,
  output logic [12:0] o_prefetch_addr,
  output logic o_vector_req,
  output logic [12:0] o_vector_addr,
  output logic o_device_reset,
  // Clock and watchdog control
  output logic o_osc_driver_en,
  output logic o_watchdog_clear,
  // I/O hold
  output logic [7:0] o_port_out,
  output logic [7:0] o_port_oe,
  // Status
  output logic o_power_down_flag,
  output logic o_timeout_flag
);

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  swc_pkg::swc_state_type state_q;
  swc_pkg::swc_cause_type cause_q;
  logic [1:0] ctrl_q;
  logic [6:0] int_en_q;
  logic ack_q;
  logic ost_start;
  logic ost_done;
  logic pend_int;
  logic wake_evt;
  logic wd_en;
  logic xtal;

  // Decide whether any enabled source is flagged; global enable is ignored
  function automatic logic any_pending(input logic [6:0] flags, input logic [6:0] en);
    any_pending = |(flags & en);
  endfunction

  assign wd_en = ctrl_q[swc_pkg::CTRL_WDT_EN_BIT];
  assign xtal = ctrl_q[swc_pkg::CTRL_XTAL_BIT];
  assign pend_int = any_pending(i_int_flags, int_en_q);
  assign wake_evt = pend_int || (wd_en && i_watchdog_timeout);
  assign ost_start = (state_q == swc_pkg::ST_SLEEP) && wake_evt && xtal;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Every access stalls one cycle, so read data comes from a flop
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_comb begin
    avs_waitrequest = (avs_read || avs_write) && !ack_q;
  end

  // Writable control and enable registers
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= swc_pkg::CTRL_RESET;
      int_en_q <= swc_pkg::INT_EN_RESET;
    end else if (avs_write && ack_q) begin
      if (avs_address == swc_pkg::ADDR_CTRL) begin
        ctrl_q <= avs_writedata[1:0];
      end else if (avs_address == swc_pkg::ADDR_INT_EN) begin
        int_en_q <= avs_writedata[6:0];
      end
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      if (avs_address == swc_pkg::ADDR_CTRL) begin
        avs_readdata <= {30'h0, ctrl_q};
      end else if (avs_address == swc_pkg::ADDR_STATUS) begin
        avs_readdata <= {25'h0, cause_q, state_q, o_timeout_flag, o_power_down_flag};
      end else if (avs_address == swc_pkg::ADDR_INT_EN) begin
        avs_readdata <= {25'h0, int_en_q};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Start-up timer
  // ---------------------------------------------------------------
  swc_ost_timer u_ost (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_start(ost_start),
    .o_done(ost_done)
  );

  // ---------------------------------------------------------------
  // Sleep state machine
  // ---------------------------------------------------------------
  // A master clear wake is a reset, not a state transition here
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= swc_pkg::ST_RUN;
      cause_q <= swc_pkg::WAKE_NONE;
    end else begin
      case (state_q)
        swc_pkg::ST_RUN: begin
          // halt only; pending makes halt a no-op
          if (i_halt && !pend_int) begin
            state_q <= swc_pkg::ST_SLEEP;
            cause_q <= swc_pkg::WAKE_NONE;
          end
        end
        swc_pkg::ST_SLEEP: begin
          // stay asleep; wake at once if flag rose
          if (wake_evt) begin
            cause_q <= pend_int ? swc_pkg::WAKE_INT : swc_pkg::WAKE_WDT;
            state_q <= xtal ? swc_pkg::ST_OST : swc_pkg::ST_RESUME;
          end
        end
        swc_pkg::ST_OST: begin
          if (ost_done) begin
            state_q <= swc_pkg::ST_RESUME;
          end
        end
        swc_pkg::ST_RESUME: begin
          state_q <= swc_pkg::ST_RUN;
        end
        default: begin
          state_q <= swc_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Power-down flag: set at power-up, cleared on completed entry
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_power_down_flag <= 1'b1;
      o_timeout_flag <= 1'b1;
    end else if (i_power_on) begin
      o_power_down_flag <= 1'b1;
      o_timeout_flag <= 1'b1;
    end else if (state_q == swc_pkg::ST_RUN && i_halt && !pend_int) begin
      o_power_down_flag <= 1'b0;
      o_timeout_flag <= 1'b1;
    end else if (state_q == swc_pkg::ST_SLEEP && !pend_int && wd_en && i_watchdog_timeout) begin
      o_timeout_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Core, oscillator and watchdog control
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_core_stall <= 1'b0;
      o_osc_driver_en <= 1'b1;
      o_watchdog_clear <= 1'b0;
      o_prefetch_en <= 1'b0;
      o_prefetch_addr <= 13'h0000;
      o_vector_req <= 1'b0;
      o_vector_addr <= 13'h0000;
      o_device_reset <= 1'b0;
    end else begin
      o_watchdog_clear <= 1'b0;
      o_prefetch_en <= 1'b0;
      o_vector_req <= 1'b0;
      // master clear low in any state but ST_RUN resets; otherwise reset held low
      o_device_reset <= (state_q != swc_pkg::ST_RUN) && !i_master_clear_pin;
      if (state_q == swc_pkg::ST_RUN && i_halt) begin
        o_prefetch_en <= 1'b1;
        o_prefetch_addr <= i_pc + 13'h0001;
      end
      if (state_q == swc_pkg::ST_RUN && i_halt && !pend_int) begin
        o_watchdog_clear <= wd_en;
        o_core_stall <= 1'b1;
        o_osc_driver_en <= 1'b0;
      end else if (state_q == swc_pkg::ST_SLEEP && wake_evt) begin
        o_watchdog_clear <= 1'b1;
        o_osc_driver_en <= 1'b1;
      end else if (state_q == swc_pkg::ST_RESUME) begin
        // continue in line; vector after next instruction
        o_core_stall <= 1'b0;
        o_vector_req <= (cause_q == swc_pkg::WAKE_INT) && i_global_int_enable;
        o_vector_addr <= swc_pkg::INT_VECTOR;
      end
    end
  end

  // hold port drive state while asleep
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_port_out <= 8'h00;
      o_port_oe <= 8'h00;
    end else if (state_q == swc_pkg::ST_RUN) begin
      o_port_out <= i_port_out;
      o_port_oe <= i_port_oe;
    end
  end
  // no master clear drive: this block has no master clear output

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_ENTRY_ONLY_HALT: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == swc_pkg::ST_RUN && !i_halt) |=> state_q == swc_pkg::ST_RUN)
    else $error("sleep entered without halt");
  AST_NOP_HALT: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == swc_pkg::ST_RUN && i_halt && pend_int && !i_power_on)
    |=> ($stable(o_power_down_flag) && !o_watchdog_clear))
    else $error("no-op halt changed state");
  AST_ENTRY_FLAGS: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == swc_pkg::ST_RUN && i_halt && !pend_int && !i_power_on)
    |=> (!o_power_down_flag && o_timeout_flag && o_core_stall))
    else $error("entry flags wrong");
  AST_OSC_OFF: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == swc_pkg::ST_SLEEP) |-> !o_osc_driver_en)
    else $error("oscillator on in sleep");
  AST_PORT_HOLD: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == swc_pkg::ST_SLEEP && $past(state_q) == swc_pkg::ST_SLEEP)
    |-> $stable(o_port_oe) && $stable(o_port_out))
    else $error("port drive changed in sleep");
  AST_WAKE_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == swc_pkg::ST_SLEEP && wake_evt) |=> o_watchdog_clear)
    else $error("watchdog not cleared on wake");
  AST_PREFETCH: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == swc_pkg::ST_RUN && i_halt) |=> (o_prefetch_en && o_prefetch_addr == $past(i_pc) + 13'h0001))
    else $error("prefetch address wrong");
  AST_STAY_ASLEEP: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == swc_pkg::ST_SLEEP && !wake_evt) |=> state_q == swc_pkg::ST_SLEEP)
    else $error("left sleep without wake");
  AST_OST_WAIT: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ost_start |=> (state_q == swc_pkg::ST_OST)[*8])
    else $error("start-up delay skipped");
  AST_VECTOR: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_vector_req |-> o_vector_addr == swc_pkg::INT_VECTOR && !o_core_stall)
    else $error("vector wrong");
  COV_INT_WAKE: cover property (@(posedge i_clock) disable iff (!i_rstn)
    state_q == swc_pkg::ST_SLEEP ##1 state_q == swc_pkg::ST_RESUME);
  COV_OST: cover property (@(posedge i_clock) disable iff (!i_rstn) ost_done);
  COV_VECTOR: cover property (@(posedge i_clock) disable iff (!i_rstn) o_vector_req);

endmodule

//--- tb/swc_core_model.sv
// Purpose: far-side model of core watchdog, port logic and master clear pin
// Assumes: watchdog counts only while the bench says it is enabled
// Notes: port state changes every cycle so a frozen hold is visible
`timescale 1ns/10ps
module swc_core_model #(
  parameter int WD_LIMIT = 200
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Control from bench and controller
  input wire logic i_wd_en,
  input wire logic i_wd_clear,
  input wire logic i_halt,
  input wire logic i_master_clear_pin_req,
  // Outputs to controller
  output logic o_watchdog_timeout,
  output logic [7:0] o_port_out,
  output logic [7:0] o_port_oe,
  output logic o_master_clear_pin
);
  logic [15:0] wd_cnt_q;
  logic [7:0] pat_q;

  // Live port pattern, never still, so a missing hold shows up
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) pat_q <= 8'h5a;
    else pat_q <= pat_q + 8'h01;
  end
  assign o_port_out = pat_q;
  assign o_port_oe = ~pat_q;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) wd_cnt_q <= 16'h0000;
    else if (i_wd_clear || i_halt) wd_cnt_q <= 16'h0000;
    else if (i_wd_en && wd_cnt_q < 16'(WD_LIMIT)) wd_cnt_q <= wd_cnt_q + 16'h0001;
  end
  assign o_watchdog_timeout = (wd_cnt_q == 16'(WD_LIMIT));

  // pin held high unless a scenario asks for a master clear
  assign o_master_clear_pin = !i_master_clear_pin_req;
endmodule

//--- tb/swc_sleep_ctrl_tb.sv
// Purpose: self-checking bench for the sleep and wake controller
// Assumes: bus master waits for waitrequest low, however long it takes
// Notes: each scenario drives the block and judges the result itself
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module swc_sleep_ctrl_tb;
  logic i_clock = 1'b0, i_rstn = 1'b0, i_power_on = 1'b0, i_halt = 1'b0, global_int_enable = 1'b0;
  logic [12:0] pc = 13'h0000;
  logic [6:0] flags = 7'h00;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0, wr = 1'b0, wd_en = 1'b0, master_clear_pin_req = 1'b0;
  logic [31:0] wdat = 32'h0, rdat, readdata;
  logic waitreq, stall, pf_en, vreq, dev_rst, osc_en, wclr, pd, to, wdto, master_clear_pin;
  logic [12:0] pf_addr, vaddr;
  logic [7:0] p_out, p_oe, h_out, h_oe, held;
  int num_errors = 0, cmp_count = 0;
  logic saw_clr, saw_vec, saw_rst;
  int n;

  swc_sleep_ctrl u_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_power_on(i_power_on),
    .i_halt(i_halt), .i_global_int_enable(global_int_enable), .i_pc(pc), .i_int_flags(flags),
    .i_watchdog_timeout(wdto), .i_master_clear_pin(master_clear_pin), .i_port_out(p_out),
    .i_port_oe(p_oe), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_readdata(readdata), .avs_waitrequest(waitreq),
    .o_core_stall(stall), .o_prefetch_en(pf_en), .o_prefetch_addr(pf_addr),
    .o_vector_req(vreq), .o_vector_addr(vaddr), .o_device_reset(dev_rst),
    .o_osc_driver_en(osc_en), .o_watchdog_clear(wclr), .o_port_out(h_out),
    .o_port_oe(h_oe), .o_power_down_flag(pd), .o_timeout_flag(to));

  swc_core_model #(.WD_LIMIT(200)) u_model (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_wd_en(wd_en), .i_wd_clear(wclr), .i_halt(i_halt), .i_master_clear_pin_req(master_clear_pin_req),
    .o_watchdog_timeout(wdto), .o_port_out(p_out), .o_port_oe(p_oe),
    .o_master_clear_pin(master_clear_pin));

  // ---------------------------------------------------------------
  // Clock, watchdog and verdict
  // ---------------------------------------------------------------
  initial begin
    forever #20 i_clock = ~i_clock;
  end

  // Long enough for all scenarios including the start-up wait
  initial begin
    #(40 * 20000);
    num_errors++;
    finish_test();
  end

  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Bus and core helpers
  // ---------------------------------------------------------------
  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    addr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    @(posedge i_clock);
    while (waitreq !== 1'b0) @(posedge i_clock);
    rdat = readdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic halt_at(input logic [12:0] p);
    @(posedge i_clock);
    pc <= p;
    i_halt <= 1'b1;
    @(posedge i_clock);
    i_halt <= 1'b0;
    @(negedge i_clock);
  endtask

  // Counts cycles until the stall drops, noting pulses on the way
  task automatic wait_wake(input int lim);
    n = 0;
    saw_clr = 0;
    saw_vec = 0;
    saw_rst = 0;
    while (stall === 1'b1 && n < lim) begin
      @(negedge i_clock);
      n++;
      saw_clr |= wclr;
      saw_vec |= vreq;
      saw_rst |= dev_rst;
      if (vreq === 1'b1) `CHK("vector_addr", 13'h0004, vaddr) // fixed vector
    end
    `CHK("woke", 1'b0, stall) // bounded stall
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_regs();
    bus(1'b0, 4'h4, 32'h0);
    `CHK("status", 32'h3, rdat[6:0]) // power-up flags
    bus(1'b0, 4'h0, 32'h0);
    `CHK("ctrl", 32'h0, rdat)
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    bus(1'b1, 4'h4, 32'h7f);
    bus(1'b0, 4'h4, 32'h0);
    `CHK("status_ro", 32'h3, rdat[6:0])
  endtask

  task automatic t_pending_nop();
    bus(1'b1, 4'h8, 32'h01);
    bus(1'b0, 4'h8, 32'h0);
    `CHK("int_en", 32'h01, rdat)
    bus(1'b1, 4'h0, 32'h1);
    flags <= 7'h01;
    halt_at(13'h0040);
    `CHK("nop_stall", 1'b0, stall) // halt is no-op
    `CHK("nop_flags", 2'h3, {to, pd}) // flags unchanged
    `CHK("nop_wclr", 1'b0, wclr) // watchdog untouched
    flags <= 7'h00;
  endtask

  task automatic t_int_wake(input logic g, input logic xt);
    bus(1'b1, 4'h0, {30'h0, xt, 1'b1});
    global_int_enable <= g;
    flags <= 7'h02;
    halt_at(13'h0100);
    `CHK("stall", 1'b1, stall) // entry on halt
    `CHK("osc_off", 1'b0, osc_en) // driver off
    `CHK("pd_to", 2'h2, {to, pd}) // entry flags
    `CHK("wd_clr", 1'b1, wclr) // watchdog cleared
    `CHK("prefetch", 14'h2101, {pf_en, pf_addr}) // next address
    held = h_out;
    repeat (12) @(negedge i_clock);
    `CHK("port_hold", held, h_out) // drive state held
    `CHK("port_hold_oe", ~held, h_oe) // drive enable held
    `CHK("still", 1'b1, stall) // disabled flag no wake
    @(posedge i_clock);
    flags <= 7'h03;
    wait_wake(1100);
    if (xt) `CHK("ost", 1'b1, n >= 1024 && n <= 1030) // start-up wait
    else `CHK("no_ost", 1'b1, n <= 4) // skipped
    `CHK("wake_clr", 1'b1, saw_clr) // clear on wake
    `CHK("vector", g, saw_vec) // global enable
    `CHK("no_reset", 1'b0, saw_rst) // resume
    `CHK("osc_on", 1'b1, osc_en)
    flags <= 7'h00;
  endtask

  task automatic t_wd_wake();
    bus(1'b1, 4'h8, 32'h00);
    bus(1'b1, 4'h0, 32'h1);
    wd_en <= 1'b1;
    halt_at(13'h0200);
    wait_wake(300);
    `CHK("wd_to", 1'b0, to) // time-out flag cleared
    `CHK("wd_clr", 1'b1, saw_clr) // clear on wake
    `CHK("wd_rst", 1'b0, saw_rst) // no reset
    wd_en <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    `CHK("cause", 2'h1, rdat[6:5])
  endtask

  task automatic t_master_clear_pin_wake();
    bus(1'b1, 4'h0, 32'h0);
    halt_at(13'h0300);
    @(posedge i_clock);
    master_clear_pin_req <= 1'b1;
    repeat (3) @(negedge i_clock);
    `CHK("master_clear_pin_rst", 1'b1, dev_rst) // full reset
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    master_clear_pin_req <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    `CHK("after_rst", 32'h3, rdat[6:0]) // reset state
    `CHK("after_stall", 1'b0, stall)
  endtask

  initial begin
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'b1;
    i_power_on <= 1'b1;
    @(posedge i_clock);
    i_power_on <= 1'b0;
    t_reset_regs();
    t_pending_nop();
    t_int_wake(1'b1, 1'b0);
    t_int_wake(1'b0, 1'b0);
    t_int_wake(1'b0, 1'b1);
    t_wd_wake();
    t_master_clear_pin_wake();
    finish_test();
  end
endmodule
